// [core/rid_pkg.sv]
// Constants, register map and types of the remappable interrupt index decoder
package rid_pkg;
	// ------------------------------------------------------------
	// Request decode fields
	// ------------------------------------------------------------
	localparam logic [11:0] INT_ID        = 12'hFEE;
	localparam int          ID_LSB        = 20;
	localparam int          HANDLE_LO_MSB = 19;
	localparam int          HANDLE_LO_LSB = 5;
	localparam int          FORMAT_BIT    = 4;
	localparam int          SHV_BIT       = 3;
	localparam int          HANDLE_HI_BIT = 2;
	localparam int          SUB_MSB       = 15;
	localparam int          RSVD_LSB      = 16;

	// ------------------------------------------------------------
	// Table geometry
	// ------------------------------------------------------------
	localparam int          ENTRY_W     = 128;
	localparam logic [3:0]  ENTRY_PAD   = 4'h0;
	localparam logic [16:0] MAX_ENTRIES = 17'h10000;
	localparam int          CACHE_LINES = 8;
	localparam int          CACHE_IW    = 3;

	// ------------------------------------------------------------
	// Register map (word address, byte address is four times it)
	// ------------------------------------------------------------
	localparam logic [2:0]  REG_CTRL   = 3'h0;
	localparam logic [2:0]  REG_BASE   = 3'h1;
	localparam logic [2:0]  REG_SIZE   = 3'h2;
	localparam logic [2:0]  REG_FAULT  = 3'h3;
	localparam logic [2:0]  REG_STATUS = 3'h4;
	localparam logic [2:0]  REG_MASK   = 3'h5;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_INVAL = 1;
	localparam int          ST_FAULT   = 0;
	localparam int          ST_REMAP   = 1;
	localparam int          ST_COMPAT  = 2;
	localparam int          FLT_IDX_LSB = 8;

	// ------------------------------------------------------------
	// Reset values and fault reasons
	// ------------------------------------------------------------
	localparam logic        EN_RST     = 1'b0;
	localparam logic [31:0] BASE_RST   = 32'h00000000;
	localparam logic [16:0] SIZE_RST   = 17'h00000;
	localparam logic [2:0]  EVT_RST    = 3'h0;
	localparam logic [7:0]  RSN_RSVD   = 8'h20;
	localparam logic [7:0]  RSN_BOUND  = 8'h21;
	localparam logic [7:0]  RSN_RST    = 8'h00;

	typedef enum logic [1:0] {S_IDLE, S_DECODE, S_FETCH, S_EMIT} rid_state_t;
endpackage : rid_pkg

// [core/rid_entry_cache.sv]
// Small direct-mapped cache of remap table entries with whole-cache invalidation
module rid_entry_cache (
	input  wire logic                          clock,
	input  wire logic                          rstn,
	input  wire logic [15:0]                   lookupIndex,
	output logic                               hit,
	output logic [rid_pkg::ENTRY_W-1:0]        hitEntry,
	input  wire logic                          fillEn,
	input  wire logic [15:0]                   fillIndex,
	input  wire logic [rid_pkg::ENTRY_W-1:0]   fillEntry,
	input  wire logic                          invalidate
);
	logic [rid_pkg::CACHE_LINES-1:0] valid_q;
	logic [rid_pkg::CACHE_LINES-1:0] valid_d;
	logic [15-rid_pkg::CACHE_IW:0]   tag_q [rid_pkg::CACHE_LINES];
	logic [rid_pkg::ENTRY_W-1:0]     data_q [rid_pkg::CACHE_LINES];
	logic [rid_pkg::CACHE_IW-1:0]    lookLine;
	logic [rid_pkg::CACHE_IW-1:0]    fillLine;

	assign lookLine = lookupIndex[rid_pkg::CACHE_IW-1:0];
	assign fillLine = fillIndex[rid_pkg::CACHE_IW-1:0];
	assign hit      = valid_q[lookLine] && (tag_q[lookLine] == lookupIndex[15:rid_pkg::CACHE_IW]);
	assign hitEntry = data_q[lookLine];

	// ------------------------------------------------------------
	// Per-line state
	// ------------------------------------------------------------
	for (genvar i = 0; i < rid_pkg::CACHE_LINES; i++) begin : gLine
		// Invalidation beats a fill in the same cycle so a stale entry never lands
		always_comb begin
			valid_d[i] = valid_q[i];
			if (fillEn && int'(fillLine) == i) begin
				valid_d[i] = 1'b1;
			end
			if (invalidate) begin
				valid_d[i] = 1'b0;
			end
		end

		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				valid_q[i] <= 1'b0;
			end else begin
				valid_q[i] <= valid_d[i];
			end
		end

		always_ff @(posedge clock) begin
			if (fillEn && int'(fillLine) == i) begin
				tag_q[i]  <= fillIndex[15:rid_pkg::CACHE_IW];
				data_q[i] <= fillEntry;
			end
		end
	end

	AST_INVAL_EMPTIES: assert property (@(posedge clock) disable iff (!rstn)
		invalidate |=> (valid_q == '0)) else $error("cache kept a line after invalidation");
endmodule : rid_entry_cache

// [core/rid_decoder.sv]
// Remappable interrupt request decoder with table lookup, entry cache and register slave
//
// Behaviour
// - Address bits 31:20 equal FEE mark interrupts
// - Handle is address 19:5 plus bit 2
// - Address bit 3 is the subhandle valid flag
// - Address bits 1:0 are ignored
// - Data 31:16 must be zero when flag set
// - Data 15:0 is subhandle only when flag set
// - Each table entry is 128 bits in memory
// - Table base and count come from registers
// - Index is handle, or handle plus subhandle
// - Table holds up to 64K entries
// - Index at or above count is an error
// - Output attributes come only from the entry
// - Entry cache honours invalidation commands
// - Nonzero reserved data blocks, reason 20h
// - Failed bounds check blocks, reason 21h
// - Remapping disabled sends all interrupt requests compatibility path
module rid_decoder (
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire logic [2:0]                   avsAddress,
	input  wire logic                         avsRead,
	input  wire logic                         avsWrite,
	input  wire logic [31:0]                  avsWriteData,
	input  wire logic [3:0]                   avsByteEnable,
	output logic [31:0]                       avsReadData,
	output logic                              avsWaitrequest,
	input  wire logic                         reqValid,
	output logic                              reqReady,
	input  wire logic [31:0]                  reqAddr,
	input  wire logic [31:0]                  reqData,
	output logic                              compatValid,
	output logic [31:0]                       compatAddr,
	output logic [31:0]                       compatData,
	output logic                              memRead,
	output logic [31:0]                       memAddr,
	input  wire logic                         memReadDataValid,
	input  wire logic [rid_pkg::ENTRY_W-1:0]  memReadData,
	output logic                              remapValid,
	output logic [rid_pkg::ENTRY_W-1:0]       remapEntry,
	output logic [15:0]                       remapIndex,
	output logic                              irq
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rstSync_q;
	logic       rstn;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstn = rstSync_q[1];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return r;
	endfunction : mergeBytes

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        enable_q, enable_d;
	logic [31:0] tableBase_q, tableBase_d;
	logic [16:0] tableSize_q, tableSize_d;
	logic [2:0]  status_q, status_d;
	logic [2:0]  mask_q, mask_d;
	logic [7:0]  faultReason_q, faultReason_d;
	logic [16:0] faultIndex_q, faultIndex_d;
	logic        invalidate;
	logic        wrTake;
	logic [31:0] merged;
	logic [2:0]  events;

	assign avsWaitrequest = (avsRead || avsWrite) && !ack_q;
	assign avsReadData    = rdata_q;
	assign wrTake         = avsWrite && ack_q;
	assign irq            = |(status_q & mask_q);

	always_comb begin
		ack_d         = (avsRead || avsWrite) && !ack_q;
		rdata_d       = rdata_q;
		enable_d      = enable_q;
		tableBase_d   = tableBase_q;
		tableSize_d   = tableSize_q;
		mask_d        = mask_q;
		invalidate    = 1'b0;
		merged        = 32'h00000000;
		if (avsRead && !ack_q) begin
			unique case (avsAddress)
				rid_pkg::REG_CTRL:   rdata_d = {31'h00000000, enable_q};
				rid_pkg::REG_BASE:   rdata_d = tableBase_q;
				rid_pkg::REG_SIZE:   rdata_d = {15'h0000, tableSize_q};
				rid_pkg::REG_FAULT:  rdata_d = {7'h00, faultIndex_q, faultReason_q};
				rid_pkg::REG_STATUS: rdata_d = {29'h00000000, status_q};
				rid_pkg::REG_MASK:   rdata_d = {29'h00000000, mask_q};
				default:             rdata_d = 32'h00000000;
			endcase
		end
		if (wrTake) begin
			unique case (avsAddress)
				rid_pkg::REG_CTRL: begin
					merged     = mergeBytes({31'h00000000, enable_q}, avsWriteData, avsByteEnable);
					enable_d   = merged[rid_pkg::CTRL_EN];
					invalidate = merged[rid_pkg::CTRL_INVAL];
				end
				rid_pkg::REG_BASE: begin
					merged      = mergeBytes(tableBase_q, avsWriteData, avsByteEnable);
					tableBase_d = {merged[31:4], rid_pkg::ENTRY_PAD};
				end
				rid_pkg::REG_SIZE: begin
					merged      = mergeBytes({15'h0000, tableSize_q}, avsWriteData, avsByteEnable);
					// Counts above 64K are clamped so the index compare stays meaningful
					tableSize_d = (merged > {15'h0000, rid_pkg::MAX_ENTRIES}) ? rid_pkg::MAX_ENTRIES
						: merged[16:0];
				end
				rid_pkg::REG_MASK: begin
					merged = mergeBytes({29'h00000000, mask_q}, avsWriteData, avsByteEnable);
					mask_d = merged[2:0];
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a write-one clear in the same cycle
		status_d = status_q;
		if (wrTake && avsAddress == rid_pkg::REG_STATUS && avsByteEnable[0]) begin
			status_d = status_q & ~avsWriteData[2:0];
		end
		status_d = status_d | events;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ack_q       <= 1'b0;
			rdata_q     <= 32'h00000000;
			enable_q    <= rid_pkg::EN_RST;
			tableBase_q <= rid_pkg::BASE_RST;
			tableSize_q <= rid_pkg::SIZE_RST;
			status_q    <= rid_pkg::EVT_RST;
			mask_q      <= rid_pkg::EVT_RST;
		end else begin
			ack_q       <= ack_d;
			rdata_q     <= rdata_d;
			enable_q    <= enable_d;
			tableBase_q <= tableBase_d;
			tableSize_q <= tableSize_d;
			status_q    <= status_d;
			mask_q      <= mask_d;
		end
	end

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	rid_pkg::rid_state_t state_q, state_d;
	logic [31:0] rqAddr_q, rqAddr_d;
	logic [31:0] rqData_q, rqData_d;
	logic [16:0] index_q, index_d;
	logic [rid_pkg::ENTRY_W-1:0] entry_q, entry_d;
	logic        compat_q, compat_d;
	logic        remap_q, remap_d;
	logic        stale_q, stale_d;
	logic        isInt, isRemapFmt, subhandle_valid_flag, rsvdBad, boundBad, goRemap;
	logic [15:0] handle, subHandle;
	logic [16:0] index;
	logic        cacheHit;
	logic [rid_pkg::ENTRY_W-1:0] cacheEntry;
	logic        fillEn;

	assign isInt      = rqAddr_q[31:rid_pkg::ID_LSB] == rid_pkg::INT_ID;
	assign isRemapFmt = rqAddr_q[rid_pkg::FORMAT_BIT];
	assign subhandle_valid_flag        = rqAddr_q[rid_pkg::SHV_BIT];
	// Bits 1:0 of the address take part in no decode below, only in compatAddr
	assign handle     = {rqAddr_q[rid_pkg::HANDLE_HI_BIT],
		rqAddr_q[rid_pkg::HANDLE_LO_MSB:rid_pkg::HANDLE_LO_LSB]};
	assign subHandle  = subhandle_valid_flag ? rqData_q[rid_pkg::SUB_MSB:0] : 16'h0000;
	assign index      = {1'b0, handle} + {1'b0, subHandle};
	assign rsvdBad    = subhandle_valid_flag && (rqData_q[31:rid_pkg::RSVD_LSB] != 16'h0000);
	assign boundBad   = index >= tableSize_q;
	assign goRemap    = isInt && enable_q && isRemapFmt;

	assign reqReady    = state_q == rid_pkg::S_IDLE;
	assign memRead     = state_q == rid_pkg::S_FETCH;
	assign memAddr     = tableBase_q + {12'h000, index_q[15:0], rid_pkg::ENTRY_PAD};
	assign compatValid = compat_q;
	assign compatAddr  = rqAddr_q;
	assign compatData  = rqData_q;
	assign remapValid  = remap_q;
	assign remapEntry  = entry_q;
	assign remapIndex  = index_q[15:0];
	assign fillEn      = memRead && memReadDataValid && !stale_q && !invalidate;

	rid_entry_cache uCache (
		.clock       (clock),
		.rstn        (rstn),
		.lookupIndex (index[15:0]),
		.hit         (cacheHit),
		.hitEntry    (cacheEntry),
		.fillEn      (fillEn),
		.fillIndex   (index_q[15:0]),
		.fillEntry   (memReadData),
		.invalidate  (invalidate)
	);

	always_comb begin
		state_d       = state_q;
		rqAddr_d      = rqAddr_q;
		rqData_d      = rqData_q;
		index_d       = index_q;
		entry_d       = entry_q;
		compat_d      = 1'b0;
		remap_d       = 1'b0;
		stale_d       = stale_q;
		faultReason_d = faultReason_q;
		faultIndex_d  = faultIndex_q;
		events        = rid_pkg::EVT_RST;
		unique case (state_q)
			rid_pkg::S_IDLE: begin
				if (reqValid) begin
					rqAddr_d = reqAddr;
					rqData_d = reqData;
					state_d  = rid_pkg::S_DECODE;
				end
			end
			rid_pkg::S_DECODE: begin
				index_d = index;
				state_d = rid_pkg::S_IDLE;
				if (isInt && !goRemap) begin
					compat_d                   = 1'b1;
					events[rid_pkg::ST_COMPAT] = 1'b1;
				end else if (goRemap && rsvdBad) begin
					faultReason_d             = rid_pkg::RSN_RSVD;
					faultIndex_d              = index;
					events[rid_pkg::ST_FAULT] = 1'b1;
				end else if (goRemap && boundBad) begin
					faultReason_d             = rid_pkg::RSN_BOUND;
					faultIndex_d              = index;
					events[rid_pkg::ST_FAULT] = 1'b1;
				end else if (goRemap && cacheHit) begin
					entry_d = cacheEntry;
					state_d = rid_pkg::S_EMIT;
				end else if (goRemap) begin
					stale_d = 1'b0;
					state_d = rid_pkg::S_FETCH;
				end
			end
			rid_pkg::S_FETCH: begin
				// An invalidation during the fetch keeps the returning entry out of the cache
				if (invalidate) begin
					stale_d = 1'b1;
				end
				if (memReadDataValid) begin
					entry_d = memReadData;
					state_d = rid_pkg::S_EMIT;
				end
			end
			rid_pkg::S_EMIT: begin
				remap_d                   = 1'b1;
				events[rid_pkg::ST_REMAP] = 1'b1;
				state_d                   = rid_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q       <= rid_pkg::S_IDLE;
			rqAddr_q      <= 32'h00000000;
			rqData_q      <= 32'h00000000;
			index_q       <= 17'h00000;
			entry_q       <= '0;
			compat_q      <= 1'b0;
			remap_q       <= 1'b0;
			stale_q       <= 1'b0;
			faultReason_q <= rid_pkg::RSN_RST;
			faultIndex_q  <= 17'h00000;
		end else begin
			state_q       <= state_d;
			rqAddr_q      <= rqAddr_d;
			rqData_q      <= rqData_d;
			index_q       <= index_d;
			entry_q       <= entry_d;
			compat_q      <= compat_d;
			remap_q       <= remap_d;
			stale_q       <= stale_d;
			faultReason_q <= faultReason_d;
			faultIndex_q  <= faultIndex_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic inDecode;
	assign inDecode = state_q == rid_pkg::S_DECODE;

	sequence sFetchDone;
		memRead && memReadDataValid;
	endsequence
	sequence sEmitFetched;
		##1 1'b1 ##1 remapValid;
	endsequence

	AST_NON_INTERRUPT_DROPPED: assert property (inDecode && !isInt |=>
		!compatValid && !memRead && state_q == rid_pkg::S_IDLE ##1 !remapValid)
		else $error("non interrupt write was processed");
	AST_HANDLE_ONLY: assert property (inDecode && goRemap && !subhandle_valid_flag |=>
		index_q == {1'b0, $past(rqAddr_q[2]), $past(rqAddr_q[19:5])}) else $error("handle index wrong");
	AST_SUM_INDEX: assert property (inDecode && goRemap && subhandle_valid_flag |=>
		index_q == {1'b0, $past(rqAddr_q[2]), $past(rqAddr_q[19:5])} + {1'b0, $past(rqData_q[15:0])})
		else $error("subhandle sum wrong");
	AST_RESERVED_FAULT: assert property (inDecode && goRemap && rsvdBad |=>
		faultReason_q == 8'h20 && status_q[0] && state_q == rid_pkg::S_IDLE ##1 !remapValid)
		else $error("reserved data not blocked");
	AST_BOUND_FAULT: assert property (inDecode && goRemap && !rsvdBad && index >= tableSize_q |=>
		faultReason_q == 8'h21 && status_q[0] ##1 !remapValid) else $error("bounds check not blocked");
	AST_COMPAT_WHEN_OFF: assert property (inDecode && isInt && !enable_q |=>
		compatValid && !memRead ##1 !remapValid) else $error("disabled remap took remap path");
	AST_FETCH_ADDRESS: assert property (inDecode && goRemap && !rsvdBad && !boundBad && !cacheHit |=>
		memRead && memAddr == tableBase_q + {12'h000, $past(index[15:0]), 4'h0}) else $error("fetch address wrong");
	AST_ENTRY_FORWARDED: assert property (sFetchDone |-> sEmitFetched ##0
		remapEntry == $past(memReadData, 2)) else $error("output not taken from fetched entry");
	AST_IRQ_FOLLOWS: assert property (status_q[rid_pkg::ST_FAULT] && mask_q[rid_pkg::ST_FAULT] |-> irq)
		else $error("unmasked fault without interrupt");
endmodule : rid_decoder

// [tb/rid_mem_model.sv]
// Memory-resident remap table model answering entry fetches promptly or slowly
module rid_mem_model (
	input  wire logic          clock,
	input  wire logic          memRead,
	input  wire logic [31:0]   memAddr,
	input  wire logic [7:0]    gen,
	input  wire logic          slow,
	output logic               memReadDataValid,
	output logic [127:0]       memReadData
);
	timeunit 1ns;
	timeprecision 1ns;
	int   waitCnt;
	logic busy;
	initial begin
		memReadDataValid = 1'h0;
		memReadData = 128'h0;
		waitCnt = 0;
		busy = 1'h0;
	end
	always @(posedge clock) begin
		memReadDataValid <= 1'h0;
		// Idle data keeps moving so a stale value can never pass for a fetched entry
		memReadData <= ~memReadData;
		// The read stays up in the edge that takes the answer; that must not start a second fetch
		if (memRead && !busy && !memReadDataValid) begin
			busy <= 1'h1;
			waitCnt <= slow ? 6 : 0;
		end else if (busy && waitCnt > 0) begin
			waitCnt <= waitCnt - 1;
		end else if (busy) begin
			busy <= 1'h0;
			memReadDataValid <= 1'h1;
			memReadData <= {{4{gen}}, ~memAddr, memAddr, {4{gen}} ^ memAddr};
		end
	end
endmodule : rid_mem_model

// [tb/remappable_interrupt_index_decoder_test.sv]
// Self-checking bench of the remappable interrupt index decoder
module remappable_interrupt_index_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] TBASE = 32'h00012340;
	localparam logic [15:0] TSIZE = 16'h0028;
	logic         clock = 1'h0;
	logic         resetn = 1'h0;
	logic [2:0]   avsAddress = 3'h0;
	logic         avsRead = 1'h0;
	logic         avsWrite = 1'h0;
	logic [31:0]  avsWriteData = 32'h0;
	logic [31:0]  avsReadData;
	logic         avsWaitrequest;
	logic         reqValid = 1'h0;
	logic         reqReady;
	logic [31:0]  reqAddr = 32'h0;
	logic [31:0]  reqData = 32'h0;
	logic         compatValid;
	logic [31:0]  compatAddr;
	logic [31:0]  compatData;
	logic         memRead;
	logic [31:0]  memAddr;
	logic         memReadDataValid;
	logic [127:0] memReadData;
	logic         remapValid;
	logic [127:0] remapEntry;
	logic [15:0]  remapIndex;
	logic         irq;
	logic [7:0]   gen = 8'h01;
	logic         slow = 1'h0;
	logic [31:0]  rd;
	logic [143:0] expR[$];
	logic [63:0]  expC[$];
	int           failures = 0;
	int           check_count = 0;

	always #25 clock = ~clock;

	rid_decoder dut (.clock(clock), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
		.avsWaitrequest(avsWaitrequest), .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
		.reqData(reqData), .compatValid(compatValid), .compatAddr(compatAddr), .compatData(compatData),
		.memRead(memRead), .memAddr(memAddr), .memReadDataValid(memReadDataValid), .memReadData(memReadData),
		.remapValid(remapValid), .remapEntry(remapEntry), .remapIndex(remapIndex), .irq(irq));

	rid_mem_model table_model (.clock(clock), .memRead(memRead), .memAddr(memAddr), .gen(gen), .slow(slow),
		.memReadDataValid(memReadDataValid), .memReadData(memReadData));

	// ------------------------------------------------------------
	// Closing and comparison
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask : check_reg

	task automatic check_remap(input logic [143:0] got);
		logic [143:0] e;
		e = (expR.size() > 0) ? expR.pop_front() : 144'hx;
		check_count++;
		if (got !== e) begin
			failures++;
			$display("unexpected at %0t: remapped %h, wanted %h", $time, got, e);
		end
	endtask : check_remap

	task automatic check_compat(input logic [63:0] got);
		logic [63:0] e;
		e = (expC.size() > 0) ? expC.pop_front() : 64'hx;
		check_count++;
		if (got !== e) begin
			failures++;
			$display("unexpected at %0t: pass-through %h, wanted %h", $time, got, e);
		end
	endtask : check_compat

	// Output watcher: every pulse must match the oldest note
	always @(posedge clock) begin
		if (remapValid === 1'h1) check_remap({remapEntry, remapIndex});
		if (compatValid === 1'h1) check_compat({compatAddr, compatData});
	end

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= d;
		@(posedge clock);
		while (avsWaitrequest !== 1'h0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) check_reg(32'h1, 32'h0);
		rd = avsReadData;
		avsWrite <= 1'h0;
		avsRead <= 1'h0;
	endtask : bus

	task automatic send(input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		reqAddr <= a;
		reqData <= d;
		reqValid <= 1'h1;
		n = 0;
		@(negedge clock);
		while (reqReady !== 1'h1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		@(posedge clock);
		reqValid <= 1'h0;
		n = 0;
		@(negedge clock);
		while (reqReady !== 1'h1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		if (n == 40) check_reg(32'h2, 32'h0);
		repeat (3) @(posedge clock);
	endtask : send

	// Remappable request; format bit always one, low address bits random
	task automatic remap(input logic [15:0] h, input logic subhandle_valid_flag, input logic [15:0] sub, input logic [15:0] hi,
		input logic ok);
		logic [31:0] a;
		logic [31:0] d;
		logic [15:0] idx;
		logic [31:0] ea;
		a = {12'hFEE, h[14:0], 1'h1, subhandle_valid_flag, h[15], 2'($urandom)};
		d = subhandle_valid_flag ? {hi, sub} : $urandom;
		idx = subhandle_valid_flag ? h + sub : h;
		ea = TBASE + {12'h0, idx, 4'h0};
		if (ok) expR.push_back({{4{gen}}, ~ea, ea, {4{gen}} ^ ea, idx});
		send(a, d);
	endtask : remap

	task automatic check_irq(input logic e);
		@(negedge clock);
		check_reg({31'h0, irq}, {31'h0, e});
	endtask : check_irq

	initial begin
		#2000000;
		failures++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		logic [3:0]  a;
		logic [15:0] h;
		logic [15:0] s;
		logic        v;
		void'($urandom(91));
		repeat (3) @(posedge clock);
		resetn <= 1'h1;
		repeat (4) @(posedge clock);
		for (a = 4'h0; a < 4'h8; a++) begin
			bus(1'h0, a[2:0], 32'h0);
			check_reg(rd, 32'h0);
		end
		$display("test reset values done");
		bus(1'h1, rid_pkg::REG_BASE, TBASE);
		bus(1'h1, rid_pkg::REG_SIZE, {16'h0, TSIZE});
		expC.push_back({32'hFEE000B8, 32'h00001234});
		send(32'hFEE000B8, 32'h00001234);
		bus(1'h1, rid_pkg::REG_CTRL, 32'h1);
		expC.push_back({32'hFEE000E0, 32'h00000041});
		send(32'hFEE000E0, 32'h00000041);
		send(32'hFED00010, 32'h0);
		$display("test pass-through done");
		for (int i = 0; i < 12; i++) begin
			h = 16'($urandom % 20);
			s = 16'($urandom % 20);
			v = 1'($urandom);
			slow <= 1'($urandom);
			remap(h, v, s, 16'h0, 1'h1);
			remap(h, v, s, 16'h0, 1'h1);
		end
		$display("test random lookups done");
		remap(TSIZE - 16'h6, 1'h1, 16'h5, 16'h0, 1'h1);
		remap(TSIZE - 16'h5, 1'h1, 16'h5, 16'h0, 1'h0);
		bus(1'h0, rid_pkg::REG_FAULT, 32'h0);
		check_reg(rd, {7'h0, 1'h0, TSIZE, 8'h21});
		remap(16'h8003, 1'h0, 16'h0, 16'h0, 1'h0);
		bus(1'h0, rid_pkg::REG_FAULT, 32'h0);
		check_reg(rd, {7'h0, 17'h08003, 8'h21});
		$display("test bounds done");
		bus(1'h1, rid_pkg::REG_STATUS, 32'h7);
		bus(1'h1, rid_pkg::REG_MASK, 32'h0);
		remap(16'h2, 1'h1, 16'h1, 16'h8000, 1'h0);
		bus(1'h0, rid_pkg::REG_FAULT, 32'h0);
		check_reg(rd & 32'hFF, 32'h20);
		bus(1'h0, rid_pkg::REG_STATUS, 32'h0);
		check_reg(rd, 32'h1);
		check_irq(1'h0);
		bus(1'h1, rid_pkg::REG_MASK, 32'h1);
		check_irq(1'h1);
		bus(1'h1, rid_pkg::REG_STATUS, 32'h1);
		check_irq(1'h0);
		$display("test reserved fault and interrupt done");
		remap(16'h3, 1'h0, 16'h0, 16'h0, 1'h1);
		gen <= 8'h2;
		bus(1'h1, rid_pkg::REG_CTRL, 32'h3);
		remap(16'h3, 1'h0, 16'h0, 16'h0, 1'h1);
		$display("test invalidation done");
		bus(1'h1, rid_pkg::REG_SIZE, 32'h0001FFFF);
		bus(1'h0, rid_pkg::REG_SIZE, 32'h0);
		check_reg(rd, 32'h00010000);
		remap(16'hFFFF, 1'h0, 16'h0, 16'h0, 1'h1);
		$display("test full table done");
		check_reg(expR.size() + expC.size(), 32'h0);
		finish_test();
	end
endmodule : remappable_interrupt_index_decoder_test
